// [testbench/image_sensor_serial_downlink_test.sv]
// Bench joining both link ends through link_if; the FIFO is tested through the sensor end.
// Assumes 100 MHz mclk; only the first rows of frame one fit in the run.
`timescale 1ns/10ps
module image_sensor_serial_downlink_test;
   import link_pkg::*;
   localparam int LIMIT = 70000;
   localparam int TRN = 8 * PP_CYCLES;
   localparam int ROW = 320 * PP_CYCLES;
   localparam int RSY = 656 * PP_CYCLES;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic srcValid = 1'b0;
   logic [PIX_BITS-1:0] srcData = '0;
   logic [UP_FRAME_BITS-1:0] upWord = '0;
   logic [4:0] dlyRows = 5'h00;
   logic devReady, underrun, hostValid, rowStart, frameEnd, upActive;
   logic [PIX_BITS-1:0] hostData;
   phase_e phase;
   phase_e lastPhase = PH_RESYNC;
   logic took = 1'b0;
   logic feedOn = 1'b0;
   int mismatches = 0;
   int checks_done = 0;
   int cyc = 0;
   int accepted = 0;
   int changes = 0;
   int rowsSeen = 0;
   int pixInRow = 0;
   int zeroSeen = 0;
   int underrunSeen = 0;
   int phaseStart = 0;
   int earlyEnd = 0;
   logic [PIX_BITS-1:0] expQ[$];
   int lenQ[$];
   link_if link();
   link_device u_link_device (.mclk(mclk), .rst_n(rst_n), .link(link.device),
      .singleEndedLinkMode(1'b0), .delayRows(dlyRows), .pixValid(srcValid),
      .pixReady(devReady), .pixData(srcData), .phase(phase), .underrun(underrun));
   link_host u_link_host (.mclk(mclk), .rst_n(rst_n), .link(link.host),
      .singleEndedLinkMode(1'b0), .upWord(upWord), .pixData(hostData), .pixValid(hostValid),
      .rowStart(rowStart), .frameEnd(frameEnd), .upActive(upActive));
   link_checker u_link_checker (.mclk(mclk), .rst_n(rst_n), .devPO(link.devPO),
      .devPOe(link.devPOe), .devNO(link.devNO), .devNOe(link.devNOe),
      .hostPOe(link.hostPOe), .hostNOe(link.hostNOe), .lineP(link.lineP));
   always #5 mclk = ~mclk;
   // ==========================================
   // Shared tasks
   task automatic chk(input string name, input logic [31:0] expV, input logic [31:0] gotV);
      checks_done++;
      if (gotV !== expV) begin
         mismatches++;
         $display("CHECK FAILED %s expected %0h seen %0h", name, expV, gotV);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Holds a word until the coming edge takes it; notes it as expected
   task automatic feeder();
      forever begin
         @(negedge mclk);
         if (took || !srcValid) begin
            srcValid = feedOn && ($urandom_range(3) != 0);
            srcData = PIX_BITS'($urandom());
         end
         took = srcValid && devReady;
         if (took) begin
            expQ.push_back(srcData);
            accepted++;
         end
      end
   endtask
   task automatic wait_changes(input int n);
      while (changes < n) @(negedge mclk);
   endtask
   // Sensor FIFO fills during resync; nothing is popped before the first row
   task automatic fifo_test();
      repeat (200) @(negedge mclk);
      chk("device fifo fill", FIFO_DEPTH, accepted);
      chk("device ready when full", 0, devReady);
      repeat (50) @(negedge mclk);
      chk("fifo holds when full", FIFO_DEPTH, accepted);
      chk("fifo queue", FIFO_DEPTH, expQ.size());
      chk("fifo no early pop", 0, underrunSeen + zeroSeen);
   endtask
   task automatic capture_word();
      logic [23:0] seen, want;
      logic [11:0] w;
      logic lastP;
      int k;
      k = 0;
      lastP = 1'b0;
      while (!(lastP === 1'b1 && link.lineP === 1'b1) && k < 400) begin
         lastP = link.lineP;
         @(negedge mclk);
         k++;
      end
      w[0] = START_BIT;
      w[11] = STOP_BIT;
      for (k = 0; k < 10; k++) w[k + 1] = expQ[0][9 - k];
      for (k = 0; k < 24; k++) begin
         want[k] = w[k / 2] ^ k[0];
         seen[k] = link.lineP;
         if (k < 23) @(negedge mclk);
      end
      chk("first pixel on wire", want, seen);
   endtask
   // ==========================================
   // Watchers
   always @(posedge mclk) begin
      cyc++;
      if (cyc == LIMIT) begin
         mismatches++;
         wrap_up();
      end
   end
   always @(negedge mclk) begin
      if (hostValid === 1'b1) begin
         pixInRow++;
         if (expQ.size() > 0) begin
            chk("pixel word", expQ.pop_front(), hostData);
         end else begin
            zeroSeen++;
            chk("underrun word", 0, hostData);
         end
      end
      if (underrun === 1'b1) underrunSeen++;
      if (rst_n && (frameEnd !== 1'b0 || upActive !== 1'b0)) earlyEnd++;
      if (rowStart === 1'b1) begin
         if (rowsSeen > 0) chk("pixels per row", 320, pixInRow);
         rowsSeen++;
         pixInRow = 0;
      end
      if (rst_n && phase !== lastPhase) begin
         if (changes == 0) chk("resync span", 1, (cyc - phaseStart) inside {[RSY:RSY + 4]});
         else if (lenQ.size() > 0) chk("phase span", lenQ.pop_front(), cyc - phaseStart);
         changes++;
         phaseStart = cyc;
         lastPhase = phase;
      end
   end
   // ==========================================
   // Main sequence
   initial begin
      void'($urandom(74));
      repeat (4) @(posedge mclk);
      @(negedge mclk);
      rst_n = 1'b1;
      phaseStart = cyc;
      upWord = UP_FRAME_BITS'($urandom());
      dlyRows = 5'($urandom());
      lenQ = '{656 * PP_CYCLES, TRN, ROW, TRN, ROW, TRN, ROW, TRN};
      feedOn = 1'b1;
      fork
         feeder();
      join_none
      fifo_test();
      $display("test buffers done");
      wait_changes(2);
      capture_word();
      $display("test wire word done");
      // Starve the source from row three on
      wait_changes(7);
      feedOn = 1'b0;
      wait_changes(9);
      repeat (100) @(negedge mclk);
      chk("underrun zeros", 1, (underrunSeen - zeroSeen) inside {[0:1]} && zeroSeen > 0);
      chk("row starts", 4, rowsSeen);
      chk("fifo left", 0, expQ.size());
      chk("fifo ready when empty", 1, devReady);
      chk("no frame end inside readout", 0, earlyEnd);
      $display("test rows done");
      wrap_up();
   end
endmodule // image_sensor_serial_downlink_test

// [testbench/link_checker.sv]
// Wire checker for the pixel downlink, fed with the link_if signals.
// Assumes the first frame after reset runs differential with two delay blocks.
`timescale 1ns/10ps
module link_checker (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic devPO,
   input wire logic devPOe,
   input wire logic devNO,
   input wire logic devNOe,
   input wire logic hostPOe,
   input wire logic hostNOe,
   input wire logic lineP
);
   localparam int FIRST_LO = 31660;
   localparam int FIRST_HI = 31700;
   localparam int ROW_CYC = 7872;
   logic [15:0] toggleRun_q, toggleRun_d, sinceRow_q, sinceRow_d;
   logic prevP_q, seenRow_q, rowMark;
   // ==========================================
   // Helper counters
   // Long toggle run marks the training tail; pixel data never toggles that long
   assign rowMark = devNOe && lineP && prevP_q && (toggleRun_q >= 16'h00BE);
   always_comb begin
      toggleRun_d = 16'h0000;
      if (lineP != prevP_q) toggleRun_d = toggleRun_q + {15'h0000, toggleRun_q != 16'hFFFF};
      sinceRow_d = sinceRow_q + {15'h0000, sinceRow_q != 16'hFFFF};
      if (rowMark) sinceRow_d = 16'h0001;
   end
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         toggleRun_q <= 16'h0000;
         sinceRow_q <= 16'h0000;
         prevP_q <= 1'b0;
         seenRow_q <= 1'b0;
      end else begin
         toggleRun_q <= toggleRun_d;
         sinceRow_q <= sinceRow_d;
         prevP_q <= lineP;
         seenRow_q <= seenRow_q | rowMark;
      end
   end
   // ==========================================
   // Properties
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);
   sequence s_twoOnes;
      devNOe && lineP && $past(lineP);
   endsequence
   property p_diffPair;
      devNOe |-> (devNO != devPO);
   endproperty
   a_diffPair: assert property (p_diffPair)
      else $error("negative line not inverse of positive");
   property p_noClash;
      !(devPOe && hostPOe);
   endproperty
   a_noClash: assert property (p_noClash)
      else $error("both ends drive the positive line");
   property p_hostPair;
      hostPOe |-> hostNOe;
   endproperty
   a_hostPair: assert property (p_hostPair)
      else $error("upstream data driven without its clock");
   property p_releaseFirst;
      $rose(devPOe) |-> !$past(hostPOe);
   endproperty
   a_releaseFirst: assert property (p_releaseFirst)
      else $error("downstream resumed while host still drove");
   property p_highRun;
      (devNOe && lineP) [*2] |=> !(devNOe && lineP);
   endproperty
   a_highRun: assert property (p_highRun)
      else $error("line high longer than one bit");
   property p_firstRow;
      rowMark && !seenRow_q |-> (toggleRun_q >= FIRST_LO) && (toggleRun_q <= FIRST_HI);
   endproperty
   a_firstRow: assert property (p_firstRow)
      else $error("first row start at wrong distance");
   property p_rowSpacing;
      rowMark && seenRow_q |-> sinceRow_q == ROW_CYC;
   endproperty
   a_rowSpacing: assert property (p_rowSpacing)
      else $error("row starts not one row apart");
   property p_nextWord;
      rowMark |-> ##24 s_twoOnes;
   endproperty
   a_nextWord: assert property (p_nextWord)
      else $error("second pixel word not 24 cycles after first");
   c_rows: cover property (rowMark && seenRow_q);
endmodule // link_checker

// [verilog/link_device.sv]
// Sensor end of the pixel downlink: framing, line coding, frame sequencing.
// Assumes link_if on the wire side and a same-clock pixel source on the user side.
// What this block does
// - Pixel framed to 12 bits, 12x pixel rate
// - Start 1 bit0, MSB first, stop 0 bit11
// - Differential mode XORs bits with bit clock
// - Last pixel 11 bits, EOF starts immediately
// - Training word is XORed zeros
// - End-of-frame word is flat low
// - Eight training words precede every row
// - Receiver finds row by two ones, single-ended by one on clock fall
// - Eight end-of-frame words after last row
// - Resync sends training for 656 pixel periods
// - Delay sends 328-word blocks, 5-bit count
// - Upstream phase: host drives data and clock
// - Mode input selects differential or single-ended
// - Single-ended sends bits without XOR
// - Single-ended pixel period is 12 clocks
// - Single-ended launches bit per rising clock
// - Host bit clock near conversion clock
// - Receiver resynchronises after every upstream phase
// - Readout is 320 rows of 8+320 words
// - Upstream lasts 648 pixel periods, then resync
// - Host releases data driver, and clock driver unless single-ended, before downstream resumes
`timescale 1ns/10ps
module link_device (
   input wire logic mclk,
   input wire logic rst_n,
   link_if.device link,
   input wire logic singleEndedLinkMode,
   input wire logic [4:0] delayRows,
   input wire logic pixValid,
   output logic pixReady,
   input wire logic [link_pkg::PIX_BITS-1:0] pixData,
   output link_pkg::phase_e phase,
   output logic underrun
);
   import link_pkg::*;
   typedef struct packed {
      phase_e ph;
      logic [3:0] bitc;
      logic [9:0] word;
      logic [8:0] row;
      logic [5:0] blk;
      logic [5:0] blocks;
      logic half;
      logic [2:0] nSync;
      logic [1:0] mSync;
      logic [4:0] dly1;
      logic [4:0] dly2;
      logic se;
      logic [PIX_BITS-1:0] pix;
      logic po;
      logic poe;
      logic no;
      logic noe;
      logic underrun;
   } dev_s;
   dev_s s_q;
   dev_s s_d;
   logic fifoValid;
   logic [PIX_BITS-1:0] fifoData;
   logic popReq;
   logic tick;
   logic endWord;
   logic lastPix;
   logic lineBit;
   logic xorOn;
   // ==========================================
   // Pixel buffer
   pix_fifo #(
      .WIDTH(PIX_BITS),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .mclk(mclk),
      .rst_n(rst_n),
      .inValid(pixValid),
      .inReady(pixReady),
      .inData(pixData),
      .outValid(fifoValid),
      .outReady(popReq),
      .outData(fifoData)
   );
   // ==========================================
   // Sequencer and line coder
   always_comb begin
      s_d = s_q;
      popReq = 1'b0;
      lineBit = 1'b0;
      endWord = s_q.bitc == LAST_BIT;
      lastPix = s_q.row == FRAME_ROWS - 9'h001 && s_q.word == ROW_PIXELS - 10'h001;
      // Upstream timing always runs on mclk; the host clock wire carries sclk then
      if (s_q.se && s_q.ph != PH_UP) begin
         tick = s_q.nSync[1] && !s_q.nSync[2];
      end else begin
         tick = s_q.half;
      end
      s_d.half = !s_q.half;
      s_d.nSync = {s_q.nSync[1:0], link.lineN};
      s_d.mSync = {s_q.mSync[0], singleEndedLinkMode};
      s_d.dly1 = delayRows;
      s_d.dly2 = s_q.dly1;
      s_d.underrun = 1'b0;
      if (tick) begin
         s_d.bitc = endWord ? 4'h0 : s_q.bitc + 4'h1;
         unique case (s_q.ph)
            PH_RESYNC: begin
               if (endWord) begin
                  s_d.word = s_q.word + 10'h001;
                  if (s_q.word == RESYNC_WORDS - 10'h001) begin
                     s_d.word = '0;
                     s_d.blk = '0;
                     s_d.ph = PH_DELAY;
                  end
               end
            end
            PH_DELAY: begin
               if (endWord) begin
                  s_d.word = s_q.word + 10'h001;
                  if (s_q.word == BLOCK_WORDS - 10'h001) begin
                     s_d.word = '0;
                     s_d.blk = s_q.blk + 6'h01;
                     if (s_q.blk == s_q.blocks - 6'h01) begin
                        s_d.row = '0;
                        s_d.ph = PH_TRAIN;
                     end
                  end
               end
            end
            PH_TRAIN: begin
               if (endWord) begin
                  s_d.word = s_q.word + 10'h001;
                  if (s_q.word == TRAIN_WORDS - 10'h001) begin
                     s_d.word = '0;
                     s_d.ph = PH_PIXEL;
                     popReq = 1'b1;
                  end
               end
            end
            PH_PIXEL: begin
               if (lastPix && s_q.bitc == EOF_ENTRY_BIT) begin
                  s_d.bitc = 4'h0;
                  s_d.word = '0;
                  s_d.ph = PH_EOF;
               end else if (endWord) begin
                  s_d.word = s_q.word + 10'h001;
                  popReq = 1'b1;
                  if (s_q.word == ROW_PIXELS - 10'h001) begin
                     s_d.word = '0;
                     s_d.row = s_q.row + 9'h001;
                     s_d.ph = PH_TRAIN;
                     popReq = 1'b0;
                  end
               end
            end
            PH_EOF: begin
               if (endWord) begin
                  s_d.word = s_q.word + 10'h001;
                  if (s_q.word == EOF_WORDS - 10'h001) begin
                     s_d.word = '0;
                     s_d.ph = PH_UP;
                  end
               end
            end
            PH_UP: begin
               if (endWord) begin
                  s_d.word = s_q.word + 10'h001;
                  if (s_q.word == UP_WORDS - 10'h001) begin
                     s_d.word = '0;
                     s_d.ph = PH_RESYNC;
                     // Mode and delay change only between frames
                     s_d.se = s_q.mSync[1];
                     s_d.blocks = {1'b0, s_q.dly2} + MIN_BLOCKS;
                  end
               end
            end
            default: begin
               s_d.word = '0;
               s_d.ph = PH_RESYNC;
            end
         endcase
      end
      // Starved source sends a zero pixel rather than stalling the line
      if (popReq) begin
         s_d.pix = fifoValid ? fifoData : '0;
         s_d.underrun = !fifoValid;
      end
      if (s_q.ph == PH_PIXEL) begin
         if (s_q.bitc == 4'h0) begin
            lineBit = START_BIT;
         end else if (s_q.bitc == LAST_BIT) begin
            lineBit = STOP_BIT;
         end else begin
            lineBit = s_q.pix[4'hA - s_q.bitc];
         end
      end
      // Training, resync and delay are zero bits, so in differential mode they code as clock only
      xorOn = !s_q.se && s_q.ph != PH_EOF;
      s_d.po = lineBit ^ (xorOn && s_q.half);
      s_d.no = !s_d.po;
      // Wires released for the whole upstream phase
      s_d.poe = s_q.ph != PH_UP;
      s_d.noe = !s_q.se && s_q.ph != PH_UP;
   end
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         s_q <= '0;
         s_q.blocks <= MIN_BLOCKS;
      end else begin
         s_q <= s_d;
      end
   end
   // ==========================================
   // Outputs
   assign link.devPO = s_q.po;
   assign link.devPOe = s_q.poe;
   assign link.devNO = s_q.no;
   assign link.devNOe = s_q.noe;
   assign phase = s_q.ph;
   assign underrun = s_q.underrun;
endmodule // link_device

// [verilog/link_host.sv]
// Receiver end of the pixel downlink: decoding, frame tracking, upstream drive.
// Assumes link_if on the wire side and the sensor end running the same frame plan.
`timescale 1ns/10ps
module link_host #(
   parameter int BIT_HALF = link_pkg::BIT_HALF_CYCLES,
   parameter int UP_DRIVE = link_pkg::UP_CYCLES - link_pkg::GUARD_CYCLES
) (
   input wire logic mclk,
   input wire logic rst_n,
   link_if.host link,
   input wire logic singleEndedLinkMode,
   input wire logic [link_pkg::UP_FRAME_BITS-1:0] upWord,
   output logic [link_pkg::PIX_BITS-1:0] pixData,
   output logic pixValid,
   output logic rowStart,
   output logic frameEnd,
   output logic upActive
);
   import link_pkg::*;
   typedef enum logic [2:0] {
      H_HUNT = 3'b000,
      H_PIX = 3'b001,
      H_EOF = 3'b010,
      H_GAP = 3'b011,
      H_UP = 3'b100
   } host_e;
   typedef struct packed {
      host_e st;
      logic [1:0] pSync;
      logic prev;
      logic half;
      logic [3:0] bitc;
      logic [9:0] col;
      logic [8:0] row;
      logic [PIX_BITS-1:0] sh;
      logic [13:0] cnt;
      logic [7:0] div;
      logic clk;
      logic [4:0] pulses;
      logic [UP_FRAME_BITS-1:0] up;
      logic po;
      logic poe;
      logic no;
      logic noe;
      logic [PIX_BITS-1:0] pix;
      logic pixValid;
      logic rowStart;
      logic frameEnd;
      logic upActive;
   } host_s;
   host_s s_q;
   host_s s_d;
   logic s;
   logic divEnd;
   logic fall;
   logic strobe;
   logic lastPix;
   // ==========================================
   // Decoder and phase tracker
   always_comb begin
      s_d = s_q;
      s = s_q.pSync[1];
      divEnd = s_q.div == 8'(BIT_HALF - 1);
      fall = divEnd && s_q.clk;
      strobe = singleEndedLinkMode ? fall : !s_q.half;
      lastPix = s_q.row == FRAME_ROWS - 9'h001 && s_q.col == ROW_PIXELS - 10'h001;
      s_d.pSync = {s_q.pSync[0], link.lineP};
      s_d.prev = s;
      s_d.half = !s_q.half;
      s_d.div = divEnd ? 8'h00 : s_q.div + 8'h01;
      s_d.clk = divEnd ? !s_q.clk : s_q.clk;
      s_d.pixValid = 1'b0;
      s_d.rowStart = 1'b0;
      s_d.frameEnd = 1'b0;
      unique case (s_q.st)
         H_HUNT: begin
            if (singleEndedLinkMode ? (fall && s) : (s_q.prev && s)) begin
               s_d.st = H_PIX;
               s_d.bitc = 4'h1;
               s_d.half = 1'b1;
               s_d.rowStart = 1'b1;
            end
         end
         H_PIX: begin
            if (strobe) begin
               s_d.bitc = (s_q.bitc == LAST_BIT) ? 4'h0 : s_q.bitc + 4'h1;
               if (s_q.bitc != 4'h0 && s_q.bitc != LAST_BIT) begin
                  s_d.sh = {s_q.sh[PIX_BITS-2:0], s};
               end
               if (s_q.bitc == EOF_ENTRY_BIT) begin
                  s_d.pix = {s_q.sh[PIX_BITS-2:0], s};
                  s_d.pixValid = 1'b1;
                  if (lastPix) begin
                     s_d.cnt = '0;
                     s_d.st = H_EOF;
                  end
               end
               if (s_q.bitc == LAST_BIT) begin
                  s_d.col = s_q.col + 10'h001;
                  if (s_q.col == ROW_PIXELS - 10'h001) begin
                     s_d.col = '0;
                     s_d.row = s_q.row + 9'h001;
                     s_d.st = H_HUNT;
                  end
               end
            end
         end
         H_EOF: begin
            if (strobe) begin
               s_d.cnt = s_q.cnt + 14'h0001;
               if (s_q.cnt == 14'(EOF_BITS - 1)) begin
                  s_d.cnt = '0;
                  s_d.row = '0;
                  s_d.col = '0;
                  s_d.frameEnd = 1'b1;
                  s_d.st = H_GAP;
               end
            end
         end
         H_GAP: begin
            // Waits for the sensor to let go before driving
            s_d.cnt = s_q.cnt + 14'h0001;
            if (s_q.cnt == 14'(GAP_CYCLES - 1)) begin
               s_d.cnt = '0;
               s_d.pulses = '0;
               s_d.up = upWord;
               s_d.upActive = 1'b1;
               s_d.st = H_UP;
            end
         end
         H_UP: begin
            s_d.cnt = s_q.cnt + 14'h0001;
            if (fall && s_q.pulses != 5'(UP_FRAME_BITS + 1)) begin
               s_d.pulses = s_q.pulses + 5'h01;
               if (s_q.pulses != 5'h00) begin
                  s_d.up = {s_q.up[UP_FRAME_BITS-2:0], 1'b0};
               end
            end
            // Ends a guard band early so the sensor never meets our drive
            if (s_q.cnt == 14'(UP_DRIVE - 1)) begin
               s_d.upActive = 1'b0;
               s_d.prev = 1'b0;
               s_d.st = H_HUNT;
            end
         end
         default: begin
            s_d.st = H_HUNT;
         end
      endcase
      s_d.poe = s_d.st == H_UP;
      s_d.po = s_d.poe && s_d.pulses != 5'h00 && s_d.pulses <= 5'(UP_FRAME_BITS)
         && s_d.up[UP_FRAME_BITS-1];
      s_d.no = s_d.clk;
      s_d.noe = s_d.poe || singleEndedLinkMode;
   end
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   // ==========================================
   // Outputs
   assign link.hostPO = s_q.po;
   assign link.hostPOe = s_q.poe;
   assign link.hostNO = s_q.no;
   assign link.hostNOe = s_q.noe;
   assign pixData = s_q.pix;
   assign pixValid = s_q.pixValid;
   assign rowStart = s_q.rowStart;
   assign frameEnd = s_q.frameEnd;
   assign upActive = s_q.upActive;
endmodule // link_host

// [verilog/link_if.sv]
// Two-wire link between sensor end and receiver end.
// Assumes each end drives only its own output and enable; an undriven wire reads low.
`timescale 1ns/10ps
interface link_if;
   logic devPO;
   logic devPOe;
   logic devNO;
   logic devNOe;
   logic hostPO;
   logic hostPOe;
   logic hostNO;
   logic hostNOe;
   logic lineP;
   logic lineN;
   // ==========================================
   // Wire resolution
   assign lineP = devPOe ? devPO : (hostPOe ? hostPO : 1'b0);
   assign lineN = devNOe ? devNO : (hostNOe ? hostNO : 1'b0);
   modport device (output devPO, devPOe, devNO, devNOe, input lineP, lineN);
   modport host (output hostPO, hostPOe, hostNO, hostNOe, input lineP, lineN);
endinterface

// [verilog/link_pkg.sv]
// Shared constants and phase codes for both ends of the pixel downlink.
// Assumes a single 100 MHz mclk domain on both ends.
package link_pkg;
   // ==========================================
   // Word framing
   localparam int PIX_BITS = 10;
   localparam logic [3:0] LAST_BIT = 4'hB;
   localparam logic [3:0] EOF_ENTRY_BIT = 4'hA;
   localparam logic START_BIT = 1'b1;
   localparam logic STOP_BIT = 1'b0;
   // ==========================================
   // Phase lengths in words
   localparam logic [9:0] RESYNC_WORDS = 10'h290;
   localparam logic [9:0] BLOCK_WORDS = 10'h148;
   localparam logic [5:0] MIN_BLOCKS = 6'h02;
   localparam logic [9:0] TRAIN_WORDS = 10'h008;
   localparam logic [9:0] ROW_PIXELS = 10'h140;
   localparam logic [8:0] FRAME_ROWS = 9'h140;
   localparam logic [9:0] EOF_WORDS = 10'h008;
   localparam logic [9:0] UP_WORDS = 10'h288;
   // ==========================================
   // Cycle counts
   localparam int PP_CYCLES = 24;
   localparam int UP_CYCLES = 648 * PP_CYCLES;
   localparam int GAP_CYCLES = 16;
   localparam int GUARD_CYCLES = 64;
   localparam int EOF_BITS = 96;
   localparam int UP_FRAME_BITS = 24;
   localparam int FIFO_DEPTH = 8;
   localparam int BIT_HALF_CYCLES = 8;
   typedef enum logic [2:0] {
      PH_RESYNC = 3'b000,
      PH_DELAY = 3'b001,
      PH_TRAIN = 3'b010,
      PH_PIXEL = 3'b011,
      PH_EOF = 3'b100,
      PH_UP = 3'b101
   } phase_e;
endpackage

// [verilog/pix_fifo.sv]
// Small pixel FIFO with valid/ready on both sides.
// Assumes DEPTH is a power of two; pointers wrap by overflow.
`timescale 1ns/10ps
module pix_fifo #(
   parameter int WIDTH = link_pkg::PIX_BITS,
   parameter int DEPTH = link_pkg::FIFO_DEPTH
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   import link_pkg::*;
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
      logic room;
      logic nonEmpty;
   } fifo_s;
   fifo_s s_q;
   fifo_s s_d;
   logic push;
   logic pop;
   assign push = inValid && s_q.room;
   assign pop = outReady && s_q.nonEmpty;
   // ==========================================
   // Pointers and flags
   always_comb begin
      s_d = s_q;
      if (push) begin
         s_d.mem[s_q.wp] = inData;
         s_d.wp = s_q.wp + 1'b1;
      end
      if (pop) begin
         s_d.rp = s_q.rp + 1'b1;
      end
      s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
      // Flags kept as flops so ready leaves straight from a register
      s_d.room = s_d.cnt != (AW+1)'(DEPTH);
      s_d.nonEmpty = s_d.cnt != '0;
   end
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         s_q <= '0;
         s_q.room <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end
   assign inReady = s_q.room;
   assign outValid = s_q.nonEmpty;
   assign outData = s_q.mem[s_q.rp];
endmodule // pix_fifo
